// ===== hw/rfpc_regs.svh
// Purpose: constants for the frontend pin control block.
// Assumes: included by its bare name from every design file that needs it.
// Notes: pin patterns are written {pin a, pin b}.
`ifndef RFPC_REGS_SVH
`define RFPC_REGS_SVH

// configuration select codes
`define RFPC_CFG_NONE 2'h0
`define RFPC_CFG_BYP 2'h1
`define RFPC_CFG_TRX 2'h2
`define RFPC_CFG_MCU 2'h3

// gain mapping code meaning no external LNA
`define RFPC_AGCMAP_INT 2'h0

// gain control word threshold, LNA above it
`define RFPC_GCW_LNA_THRESH 8'h11

// pin patterns {a, b}
`define RFPC_PAT_LL 2'h0
`define RFPC_PAT_LH 2'h1
`define RFPC_PAT_HL 2'h2
`define RFPC_PAT_HH 2'h3
`define RFPC_PAT_RESET 2'h0

`endif

// ===== hw/rfpc_pkg.sv
// Purpose: types for the frontend pin control block.
// Assumes: radio state codes are shared with the radio state machine.
// Notes: codes 110 and 111 are unused and decode as idle.
package rfpc_pkg;

    typedef enum logic [2:0] {
        RFPC_ST_OFF = 3'b000,
        RFPC_ST_SLEEP = 3'b001,
        RFPC_ST_RESET = 3'b010,
        RFPC_ST_TRANSMIT_PREPARE_STATE = 3'b011,
        RFPC_ST_RX = 3'b100,
        RFPC_ST_TX = 3'b101
    } rfpc_radio_t;

    typedef struct packed {
        logic [1:0] pins_hi;
        logic [1:0] pins_sub;
    } rfpc_state_t;

endpackage : rfpc_pkg

// ===== hw/rfpc_lna_sel.sv
// Purpose: decides between LNA and bypass receive for one radio.
// Assumes: gain control word comes from the same clock domain.
// Notes: purely combinational; the caller registers the result.
`timescale 1ns/1ps
`include "rfpc_regs.svh"

module rfpc_lna_sel
    import rfpc_pkg::*;
#(
    parameter int GCW_W = 5
)
(
    input wire logic [GCW_W-1:0] gcw_i,
    input wire logic bypass_en_i,
    input wire logic [1:0] agc_map_i,
    output logic use_lna_o
);

    // --------------------------------------------------------------
    // receive path choice
    // --------------------------------------------------------------
    always_comb
    begin
        if (!bypass_en_i)
        begin
            // no bypass path fitted: stay in LNA mode
            use_lna_o = 1'b1;
        end
        else if (agc_map_i == `RFPC_AGCMAP_INT)
        begin
            use_lna_o = 1'b0;
        end
        else
        begin
            use_lna_o = (gcw_i > GCW_W'(`RFPC_GCW_LNA_THRESH));
        end
    end

endmodule : rfpc_lna_sel

// ===== hw/rfpc_top.sv
// Purpose: drives the external frontend control pins of both radios.
// Assumes: radio state, configuration and gain inputs come from core-clock logic.
// Notes: pins lag their inputs by one clock; outputs come straight from flops.
`timescale 1ns/1ps
`include "rfpc_regs.svh"

module rfpc_top
    import rfpc_pkg::*;
#(
    parameter int GCW_W = 5
)
(
    input wire logic REF_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [2:0] RADIO_STATE_HIBAND_I,
    input wire logic [2:0] RADIO_STATE_SUBGHZ_I,
    input wire logic [1:0] FRONTEND_CONFIG_SELECT_HIBAND_I,
    input wire logic [1:0] FRONTEND_CONFIG_SELECT_SUBGHZ_I,
    input wire logic [GCW_W-1:0] GAIN_CONTROL_WORD_HIBAND_I,
    input wire logic [GCW_W-1:0] GAIN_CONTROL_WORD_SUBGHZ_I,
    input wire logic LNA_BYPASS_EN_HIBAND_I,
    input wire logic LNA_BYPASS_EN_SUBGHZ_I,
    input wire logic [1:0] AGC_MAP_HIBAND_I,
    input wire logic [1:0] AGC_MAP_SUBGHZ_I,
    output logic FRONTEND_CTL_A_HIBAND_O,
    output logic FRONTEND_CTL_B_HIBAND_O,
    output logic FRONTEND_CTL_A_SUBGHZ_O,
    output logic FRONTEND_CTL_B_SUBGHZ_O
);

    // --------------------------------------------------------------
    // pattern decode
    // --------------------------------------------------------------
    // both pins are chosen together as one pattern, and a pattern like low/low is legal
    function automatic logic [1:0] rfpc_pins(
        input logic [1:0] cfg,
        input rfpc_radio_t st,
        input logic use_lna
    );
        logic [1:0] p;
        p = `RFPC_PAT_LL;
        unique case (cfg)
            `RFPC_CFG_NONE:
            begin
                p = `RFPC_PAT_LL;
            end
            `RFPC_CFG_BYP:
            begin
                if (st == RFPC_ST_RX)
                begin
                    p = use_lna ? `RFPC_PAT_LH : `RFPC_PAT_HH;
                end
                else if (st == RFPC_ST_TX)
                begin
                    p = `RFPC_PAT_HL;
                end
            end
            `RFPC_CFG_TRX:
            begin
                if (st == RFPC_ST_RX)
                begin
                    p = `RFPC_PAT_LH;
                end
                else if (st == RFPC_ST_TX)
                begin
                    p = `RFPC_PAT_HH;
                end
            end
            `RFPC_CFG_MCU:
            begin
                // on/off of the module is left to a separate enable
                if (st == RFPC_ST_RX)
                begin
                    p = use_lna ? `RFPC_PAT_LH : `RFPC_PAT_LL;
                end
                else if (st == RFPC_ST_TX)
                begin
                    p = `RFPC_PAT_HH;
                end
            end
        endcase
        return p;
    endfunction : rfpc_pins

    // --------------------------------------------------------------
    // receive path choice per radio
    // --------------------------------------------------------------
    logic use_lna_hi;
    logic use_lna_sub;
    rfpc_radio_t st_hi;
    rfpc_radio_t st_sub;

    assign st_hi = rfpc_radio_t'(RADIO_STATE_HIBAND_I);
    assign st_sub = rfpc_radio_t'(RADIO_STATE_SUBGHZ_I);

    rfpc_lna_sel #(
        .GCW_W(GCW_W)
    ) u_lna_hi (
        .gcw_i(GAIN_CONTROL_WORD_HIBAND_I),
        .bypass_en_i(LNA_BYPASS_EN_HIBAND_I),
        .agc_map_i(AGC_MAP_HIBAND_I),
        .use_lna_o(use_lna_hi)
    );

    rfpc_lna_sel #(
        .GCW_W(GCW_W)
    ) u_lna_sub (
        .gcw_i(GAIN_CONTROL_WORD_SUBGHZ_I),
        .bypass_en_i(LNA_BYPASS_EN_SUBGHZ_I),
        .agc_map_i(AGC_MAP_SUBGHZ_I),
        .use_lna_o(use_lna_sub)
    );

    // --------------------------------------------------------------
    // state registers
    // --------------------------------------------------------------
    rfpc_state_t state_q;
    rfpc_state_t state_d;

    always_comb
    begin
        state_d = state_q;
        // pins recomputed every clock, so no write is needed per transition
        state_d.pins_hi = rfpc_pins(FRONTEND_CONFIG_SELECT_HIBAND_I, st_hi, use_lna_hi);
        state_d.pins_sub = rfpc_pins(FRONTEND_CONFIG_SELECT_SUBGHZ_I, st_sub, use_lna_sub);
    end

    // registering hides decode glitches from the frontend switches
    always_ff @(posedge REF_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            state_q.pins_hi <= `RFPC_PAT_RESET;
            state_q.pins_sub <= `RFPC_PAT_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign FRONTEND_CTL_A_HIBAND_O = state_q.pins_hi[1];
    assign FRONTEND_CTL_B_HIBAND_O = state_q.pins_hi[0];
    assign FRONTEND_CTL_A_SUBGHZ_O = state_q.pins_sub[1];
    assign FRONTEND_CTL_B_SUBGHZ_O = state_q.pins_sub[0];

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    logic [1:0] pins_hi_w;
    logic [1:0] pins_sub_w;
    logic rst_d1_q;
    assign pins_hi_w = {FRONTEND_CTL_A_HIBAND_O, FRONTEND_CTL_B_HIBAND_O};
    assign pins_sub_w = {FRONTEND_CTL_A_SUBGHZ_O, FRONTEND_CTL_B_SUBGHZ_O};

    always_ff @(posedge REF_CLK_I)
    begin
        rst_d1_q <= SYS_RST_I;
    end

    sequence s_hi_idle;
        (RADIO_STATE_HIBAND_I != RFPC_ST_RX) && (RADIO_STATE_HIBAND_I != RFPC_ST_TX);
    endsequence

    sequence s_hi_cfg1_rx;
        (FRONTEND_CONFIG_SELECT_HIBAND_I == `RFPC_CFG_BYP) && (RADIO_STATE_HIBAND_I == RFPC_ST_RX)
            && LNA_BYPASS_EN_HIBAND_I && (AGC_MAP_HIBAND_I != `RFPC_AGCMAP_INT);
    endsequence

    sequence s_sub_enter_rx_cfg2;
        (RADIO_STATE_SUBGHZ_I != RFPC_ST_RX) ##1
            ((RADIO_STATE_SUBGHZ_I == RFPC_ST_RX) && (FRONTEND_CONFIG_SELECT_SUBGHZ_I == `RFPC_CFG_TRX));
    endsequence

    a_cfg0_held_low: assert property (
        (FRONTEND_CONFIG_SELECT_HIBAND_I == `RFPC_CFG_NONE) |=> (pins_hi_w == `RFPC_PAT_LL))
        else $error("config 0 high band pins not low");

    a_idle_all_off: assert property (
        s_hi_idle |=> (pins_hi_w == `RFPC_PAT_LL))
        else $error("idle radio state left high band pins active");

    a_lna_above_thresh: assert property (
        s_hi_cfg1_rx and (GAIN_CONTROL_WORD_HIBAND_I > GCW_W'(`RFPC_GCW_LNA_THRESH)) |=> (pins_hi_w == `RFPC_PAT_LH))
        else $error("gain word above 17 did not select LNA mode");

    a_bypass_at_thresh: assert property (
        s_hi_cfg1_rx and (GAIN_CONTROL_WORD_HIBAND_I <= GCW_W'(`RFPC_GCW_LNA_THRESH)) |=> (pins_hi_w == `RFPC_PAT_HH))
        else $error("gain word at or below 17 did not select bypass");

    a_cfg1_tx_pins: assert property (
        (FRONTEND_CONFIG_SELECT_SUBGHZ_I == `RFPC_CFG_BYP) && (RADIO_STATE_SUBGHZ_I == RFPC_ST_TX)
            |=> FRONTEND_CTL_A_SUBGHZ_O && !FRONTEND_CTL_B_SUBGHZ_O)
        else $error("config 1 transmit pattern wrong");

    a_cfg2_tx_pins: assert property (
        (FRONTEND_CONFIG_SELECT_HIBAND_I == `RFPC_CFG_TRX) && (RADIO_STATE_HIBAND_I == RFPC_ST_TX)
            |=> (pins_hi_w == `RFPC_PAT_HH))
        else $error("config 2 transmit pattern wrong");

    a_rx_entry_follow: assert property (
        s_sub_enter_rx_cfg2 |=> (pins_sub_w == `RFPC_PAT_LH) ##0 $changed(pins_sub_w))
        else $error("sub-GHz pins did not follow receive entry");

    // skip the edge right after reset: pins there are still the forced all-off value
    a_band_independent: assert property (
        !rst_d1_q && $stable(RADIO_STATE_SUBGHZ_I) && $stable(FRONTEND_CONFIG_SELECT_SUBGHZ_I)
            && $stable(use_lna_sub) && $changed(RADIO_STATE_HIBAND_I) |=> $stable(pins_sub_w))
        else $error("sub-GHz pins moved with high band state");

    a_release_off: assert property (
        rst_d1_q |-> (pins_hi_w == `RFPC_PAT_LL) && (pins_sub_w == `RFPC_PAT_LL))
        else $error("pins not all-off right after reset");

    a_split_pins: assert property (
        (FRONTEND_CONFIG_SELECT_SUBGHZ_I == `RFPC_CFG_TRX) && (RADIO_STATE_SUBGHZ_I == RFPC_ST_OFF)
            |=> !FRONTEND_CTL_A_SUBGHZ_O && !FRONTEND_CTL_B_SUBGHZ_O)
        else $error("config 2 idle pins not both low");

endmodule : rfpc_top

// ===== dv/rfpc_fe_model.sv
// Purpose: external frontend module facing one pin pair.
// Assumes: pins are plain single-ended levels.
// Notes: mode 0 off, 1 rx lna, 2 tx, 3 rx bypass.
`timescale 1ns/1ps

module rfpc_fe_model
(
    input wire logic pin_a_i,
    input wire logic pin_b_i,
    input wire logic [1:0] cfg_i,
    output logic [1:0] mode_o
);
    // both pins read together as a pair, with the config select
    always_comb
    begin
        case ({cfg_i, pin_a_i, pin_b_i})
            4'h5, 4'h9, 4'hD: mode_o = 2'h1;
            4'h6, 4'hB, 4'hF: mode_o = 2'h2;
            4'h7, 4'hA: mode_o = 2'h3; // lna can be bypassed
            default: mode_o = 2'h0;
        endcase
    end
endmodule : rfpc_fe_model

// ===== dv/rfpc_top_tb.sv
// Purpose: self-checking bench for the frontend pin block.
// Assumes: one-cycle pin latency, synchronous reset.
// Notes: inputs change 1 ns after each rising edge.
`timescale 1ns/1ps

module rfpc_top_tb
    import rfpc_pkg::*;
;
    logic clk, rst;
    logic [2:0] st_h, st_s;
    logic [1:0] cfg_h, cfg_s, map_h, map_s, mode_h, mode_s;
    logic [4:0] gcw_h, gcw_s;
    logic byp_h, byp_s, a_h, b_h, a_s, b_s;
    int err_count = 0;
    int checks = 0;

    rfpc_top #(.GCW_W(5)) dut (.REF_CLK_I(clk), .SYS_RST_I(rst),
        .RADIO_STATE_HIBAND_I(st_h), .RADIO_STATE_SUBGHZ_I(st_s),
        .FRONTEND_CONFIG_SELECT_HIBAND_I(cfg_h), .FRONTEND_CONFIG_SELECT_SUBGHZ_I(cfg_s),
        .GAIN_CONTROL_WORD_HIBAND_I(gcw_h), .GAIN_CONTROL_WORD_SUBGHZ_I(gcw_s),
        .LNA_BYPASS_EN_HIBAND_I(byp_h), .LNA_BYPASS_EN_SUBGHZ_I(byp_s),
        .AGC_MAP_HIBAND_I(map_h), .AGC_MAP_SUBGHZ_I(map_s),
        .FRONTEND_CTL_A_HIBAND_O(a_h), .FRONTEND_CTL_B_HIBAND_O(b_h),
        .FRONTEND_CTL_A_SUBGHZ_O(a_s), .FRONTEND_CTL_B_SUBGHZ_O(b_s));
    rfpc_fe_model fe_h (.pin_a_i(a_h), .pin_b_i(b_h), .cfg_i(cfg_h), .mode_o(mode_h));
    rfpc_fe_model fe_s (.pin_a_i(a_s), .pin_b_i(b_s), .cfg_i(cfg_s), .mode_o(mode_s));

    // ----------------------------------------
    // clock, helpers
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input string name, input logic [1:0] exp, input logic [1:0] got);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    function automatic logic [1:0] exp_pins(input logic [1:0] c, input logic [2:0] s, input logic lna);
        if (c == 2'h0 || (s != RFPC_ST_RX && s != RFPC_ST_TX))
            return 2'h0;
        if (s == RFPC_ST_TX)
            return (c == 2'h1) ? 2'h2 : 2'h3;
        if (c == 2'h2)
            return 2'h1;
        return lna ? 2'h1 : ((c == 2'h1) ? 2'h3 : 2'h0);
    endfunction : exp_pins

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic sc_sweep();
        logic [1:0] ph, ps;
        ph = 2'h0;
        ps = 2'h0;
        byp_h = 1'b0;
        byp_s = 1'b0;
        for (int c = 0; c < 4; c++)
        begin
            for (int s = 0; s < 8; s++)
            begin
                cfg_h = c[1:0];
                st_h = s[2:0];
                cfg_s = 2'h3 - c[1:0];
                st_s = 3'h7 - s[2:0];
                chk("hold_hi", ph, {a_h, b_h});
                tick();
                ph = exp_pins(cfg_h, st_h, 1'b1);
                ps = exp_pins(cfg_s, st_s, 1'b1);
                chk("pins_hi", ph, {a_h, b_h});
                chk("pins_sub", ps, {a_s, b_s});
            end
        end
    endtask : sc_sweep

    task automatic sc_gain();
        logic [4:0] g [6] = '{5'h11, 5'h12, 5'h00, 5'h1F, 5'h1F, 5'h11};
        logic [1:0] m [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h2};
        logic [1:0] e [6] = '{2'h3, 2'h1, 2'h3, 2'h1, 2'h3, 2'h0};
        cfg_s = 2'h1;
        st_s = RFPC_ST_RX;
        byp_h = 1'b1;
        byp_s = 1'b0;
        gcw_s = 5'h00;
        st_h = RFPC_ST_RX;
        for (int i = 0; i < 6; i++)
        begin
            cfg_h = (i == 5) ? 2'h3 : 2'h1;
            gcw_h = g[i];
            map_h = m[i];
            tick();
            chk("gain_hi", e[i], {a_h, b_h});
            chk("gain_sub", 2'h1, {a_s, b_s});
            if (i < 5)
                chk("fe_mode", (e[i] == 2'h3) ? 2'h3 : 2'h1, mode_h);
        end
    endtask : sc_gain

    task automatic sc_reset();
        cfg_h = 2'h2;
        st_h = RFPC_ST_TX;
        tick();
        chk("tx_before", 2'h3, {a_h, b_h});
        tick();
        chk("sub_steady", 2'h1, {a_s, b_s});
        rst = 1'b1;
        tick();
        chk("in_reset", 2'h0, {a_h, b_h});
        chk("in_reset_s", 2'h0, {a_s, b_s});
        rst = 1'b0;
        tick();
        chk("release_edge", 2'h3, {a_h, b_h});
        tick();
        chk("after_reset", 2'h3, {a_h, b_h});
    endtask : sc_reset

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (5000) @(posedge clk);
        err_count++;
        complete_run();
    end

    initial
    begin
        rst = 1'b1;
        cfg_h = 2'h2;
        cfg_s = 2'h2; // frontend fitted matches selection
        st_h = RFPC_ST_TX;
        st_s = RFPC_ST_RX;
        gcw_h = 5'h00;
        gcw_s = 5'h00;
        byp_h = 1'b0;
        byp_s = 1'b0;
        map_h = 2'h0;
        map_s = 2'h0;
        repeat (3) tick();
        chk("reset_pins", 2'h0, {a_h, b_h});
        rst = 1'b0;
        cfg_h = 2'h0;
        cfg_s = 2'h0;
        tick();
        tick();
        sc_sweep();
        sc_gain();
        sc_reset();
        complete_run();
    end
endmodule : rfpc_top_tb
